// [logic/clock_fail_monitor_pkg.sv]
// constants and types for the fail-safe clock monitor
// Operation
// [R1] monitor runs only when the monitor-enable fuse is set, in every external mode
// [R2] on failure set osc fail flag bit 7; interrupt when its enable is set
// [R3] after failure system clock runs from internal oscillator at the selected frequency
// [R4] stay on internal oscillator until clock recovers and fail-safe is exited
// [R5] entering fail-safe clears external-active status bit 3 and clears the watchdog
// [R6] fail-safe leaves clock select bit 0 alone; enable leaves low osc stable alone
// [R7] sample clock is internal oscillator divided by 64
// [R8] latch clears on sample rise, sets on primary clock fall
// [R9] failure when sample clock falls while latch still clear
// [R10] monitor enable forces two-speed start-up on
// [R11] primary clock near 488 Hz or slower counts as failed
// [R12] fail-safe clears on reset, sleep, or write changing clock select
// [R13] fail flag cannot clear while fail-safe active; software clears condition first
// [R14] external clock and RC modes monitor right after reset or sleep
// [R15] crystal modes suspend detection and run internally until start-up timer expires
// [R16] after start-up the low internal oscillator again sources the monitor
// [R17] external-active status set on external source, clear on internal oscillator
// [R18] software should read external-active status after a delay to confirm switchover
// [R19] start-up timer counts 1024 external clock cycles
// [R20] any reset loads frequency select with 110, selecting 4 MHz
// [R21] failure indication is synchronised before it touches status or clock select
package clock_fail_monitor_pkg;
   localparam logic [15:0] OSC_CONTROL_ADDR = 16'h008F;
   localparam logic [15:0] OSC_TUNING_ADDR = 16'h0090;
   localparam logic [15:0] CONFIG_WORD_ADDR = 16'h2007;
   localparam logic [15:0] PERIPH_FLAG_TWO_ADDR = 16'h000D;
   localparam logic [15:0] PERIPH_INT_EN_TWO_ADDR = 16'h008D;
   localparam int FAIL_BIT = 7;
   localparam int FREQ_LSB = 4;
   localparam int STATUS_BIT = 3;
   localparam int HIGH_STABLE_BIT = 2;
   localparam int LOW_STABLE_BIT = 1;
   localparam int SELECT_BIT = 0;
   localparam logic [2:0] FREQ_RESET = 3'h6;
   localparam logic [4:0] TUNE_RESET = 5'h00;
   localparam int SAMPLE_DIV = 64;
   localparam logic [5:0] HALF_SAMPLE = 6'(SAMPLE_DIV / 2 - 1);
   localparam int STARTUP_COUNT = 1024;
   localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_COUNT);
   // oscillator mode codes of the configuration field
   localparam logic [2:0] MODE_LOW_POWER = 3'h0;
   localparam logic [2:0] MODE_CRYSTAL = 3'h1;
   localparam logic [2:0] MODE_HIGH_SPEED = 3'h2;
   localparam logic [2:0] MODE_EXTERNAL = 3'h3;
   typedef enum logic [1:0] {ST_STARTUP, ST_EXTERNAL, ST_FAILSAFE, ST_SLEEP} clk_state_t;
endpackage

// [logic/clock_fail_monitor.sv]
// fail-safe clock monitor with its oscillator control registers
`timescale 1ns/1ns
module clock_fail_monitor
   import clock_fail_monitor_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic PRIMARY_CLK,
   input wire logic [2:0] OSC_MODE_CONFIG,
   input wire logic MONITOR_ENABLE_FUSE,
   input wire logic TWO_SPEED_FUSE,
   input wire logic SLEEP_EXEC,
   input wire logic WAKE_UP,
   input wire logic [15:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   output logic OSC_FAIL_IRQ,
   output logic USE_EXTERNAL_CLK,
   output logic [2:0] INT_OSC_FREQ,
   output logic WATCHDOG_CLEAR,
   output logic TWO_SPEED_ENABLE
);
   typedef struct packed {
      logic [5:0] div;
      logic sample;
      logic prim_d;
      logic latch;
      logic fail_raw;
      logic fail_s1;
      logic fail_s2;
      logic [10:0] osc_startup_timer;
      clk_state_t state;
      logic fail_flag;
      logic fail_ie;
      logic [2:0] freq;
      logic sel;
      logic [4:0] tune;
      logic [7:0] rdata;
      logic irq;
      logic ext;
      logic wdt_clr;
      logic two_speed;
   } state_t;
   state_t cur, nxt;
   logic crystal;
   assign crystal = (OSC_MODE_CONFIG == MODE_LOW_POWER) || (OSC_MODE_CONFIG == MODE_CRYSTAL)
                    || (OSC_MODE_CONFIG == MODE_HIGH_SPEED);
   // next state of the whole block
   always_comb begin
      nxt = cur;
      nxt.wdt_clr = 1'b0;
      // sample clock by 64 from the internal clock
      nxt.div = cur.div + 6'h01;                                  // [R7]
      if (cur.div == HALF_SAMPLE) begin
         nxt.sample = 1'b1;
      end
      if (cur.div == 6'h3F) begin
         nxt.sample = 1'b0;
      end
      nxt.prim_d = PRIMARY_CLK;
      nxt.fail_raw = 1'b0;
      // latch: set on primary fall, cleared on sample rise
      if (cur.prim_d && !PRIMARY_CLK) begin
         nxt.latch = 1'b1;                                         // [R8]
      end else if (!cur.sample && nxt.sample) begin
         nxt.latch = 1'b0;                                         // [R8]
      end
      // failure on sample fall with latch clear; slow clocks miss [R11]
      if (cur.sample && !nxt.sample && !cur.latch) begin
         nxt.fail_raw = 1'b1;                                      // [R9]
      end
      nxt.fail_s1 = cur.fail_raw;                                  // [R21]
      nxt.fail_s2 = cur.fail_s1;                                   // [R21]
      // start-up timer counts primary falls
      if (cur.state == ST_STARTUP && cur.prim_d && !PRIMARY_CLK) begin
         nxt.osc_startup_timer = cur.osc_startup_timer + 11'h001;                              // [R19]
      end
      unique case (cur.state)
         ST_STARTUP: begin
            if (!crystal || cur.osc_startup_timer == STARTUP_LAST) begin           // [R14] [R15]
               nxt.state = ST_EXTERNAL;                            // [R16]
            end
         end
         ST_EXTERNAL: begin
            if (MONITOR_ENABLE_FUSE && cur.fail_s2 && !cur.sel) begin  // [R1]
               nxt.state = ST_FAILSAFE;
               nxt.fail_flag = 1'b1;                               // [R2]
               nxt.wdt_clr = 1'b1;                                 // [R5]
            end
         end
         ST_FAILSAFE: begin
            nxt.state = ST_FAILSAFE;                               // [R4]
         end
         ST_SLEEP: begin
            if (WAKE_UP) begin
               nxt.state = ST_STARTUP;
               nxt.osc_startup_timer = '0;
            end
         end
      endcase
      // register writes
      if (WR) begin
         unique case (ADDR)
            OSC_CONTROL_ADDR: begin
               nxt.freq = WDATA[FREQ_LSB +: 3];
               nxt.sel = WDATA[SELECT_BIT];                        // [R6]
               if (WDATA[SELECT_BIT] != cur.sel && cur.state == ST_FAILSAFE) begin
                  nxt.state = ST_STARTUP;                          // [R12]
                  nxt.osc_startup_timer = '0;
               end
            end
            OSC_TUNING_ADDR: nxt.tune = WDATA[4:0];
            PERIPH_FLAG_TWO_ADDR: begin
               // clear refused while in fail-safe; a new failure wins
               if (cur.state != ST_FAILSAFE && nxt.state != ST_FAILSAFE) begin
                  nxt.fail_flag = WDATA[FAIL_BIT];                 // [R13]
               end
            end
            PERIPH_INT_EN_TWO_ADDR: nxt.fail_ie = WDATA[FAIL_BIT];
            default: ;
         endcase
      end
      if (SLEEP_EXEC) begin
         nxt.state = ST_SLEEP;                                     // [R12]
         nxt.osc_startup_timer = '0;
      end
      // register reads, data one cycle later
      nxt.rdata = 8'h00;
      if (RD) begin
         unique case (ADDR)
            OSC_CONTROL_ADDR: begin
               nxt.rdata[FREQ_LSB +: 3] = cur.freq;
               nxt.rdata[STATUS_BIT] = cur.ext;                     // [R17]
               nxt.rdata[HIGH_STABLE_BIT] = 1'b1;
               nxt.rdata[LOW_STABLE_BIT] = 1'b1;                    // [R6]
               nxt.rdata[SELECT_BIT] = cur.sel;
            end
            OSC_TUNING_ADDR: nxt.rdata[4:0] = cur.tune;
            CONFIG_WORD_ADDR: nxt.rdata[2:0] = OSC_MODE_CONFIG;
            PERIPH_FLAG_TWO_ADDR: nxt.rdata[FAIL_BIT] = cur.fail_flag;
            PERIPH_INT_EN_TWO_ADDR: nxt.rdata[FAIL_BIT] = cur.fail_ie;
            default: ;
         endcase
      end
      // outputs
      nxt.irq = nxt.fail_flag && nxt.fail_ie;                      // [R2]
      nxt.ext = (nxt.state == ST_EXTERNAL) && !nxt.sel;            // [R3] [R5] [R17]
      nxt.two_speed = TWO_SPEED_FUSE || MONITOR_ENABLE_FUSE;       // [R10]
   end
   // state register
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cur <= '0;
         cur.state <= ST_STARTUP;
         cur.freq <= FREQ_RESET;                                   // [R20]
         cur.tune <= TUNE_RESET;
      end else begin
         cur <= nxt;
      end
   end
   assign RDATA = cur.rdata;
   assign OSC_FAIL_IRQ = cur.irq;
   assign USE_EXTERNAL_CLK = cur.ext;
   assign INT_OSC_FREQ = cur.freq;
   assign WATCHDOG_CLEAR = cur.wdt_clr;
   assign TWO_SPEED_ENABLE = cur.two_speed;

   a_fail_sets_flag: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (cur.state == ST_EXTERNAL && cur.fail_s2 && MONITOR_ENABLE_FUSE && !cur.sel
       && !SLEEP_EXEC) |=> cur.fail_flag && cur.state == ST_FAILSAFE) // [R2]
      else $error("failure did not set flag");
   a_failsafe_internal: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      cur.state == ST_FAILSAFE |-> !USE_EXTERNAL_CLK)   // [R3]
      else $error("fail-safe still on external clock");
   a_entry_wdt_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      $rose(cur.state == ST_FAILSAFE) |-> WATCHDOG_CLEAR) // [R5]
      else $error("watchdog not cleared on entry");
   a_select_kept: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (!$past(WR) && $rose(cur.state == ST_FAILSAFE)) |-> $stable(cur.sel)) // [R6]
      else $error("clock select changed by fail-safe");
   a_irq_gate: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      OSC_FAIL_IRQ |-> cur.fail_flag && cur.fail_ie) // [R2]
      else $error("interrupt without enable");
   a_flag_hold: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (cur.state == ST_FAILSAFE && cur.fail_flag) |=> cur.fail_flag) // [R13]
      else $error("flag cleared during fail-safe");
   a_sleep_exits: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      SLEEP_EXEC |=> cur.state == ST_SLEEP)  // [R12]
      else $error("sleep did not clear fail-safe");
   a_two_speed_on: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      MONITOR_ENABLE_FUSE |=> TWO_SPEED_ENABLE) // [R10]
      else $error("two-speed not forced");
   a_sync_delay: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      cur.fail_raw |=> ##1 cur.fail_s2) // [R21]
      else $error("sync chain broken");
   a_startup_wait: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
      (cur.state == ST_STARTUP && crystal && cur.osc_startup_timer != STARTUP_LAST) |=>
         cur.state != ST_EXTERNAL) // [R15]
      else $error("left start-up early");
   c_failsafe: cover property (@(posedge SYS_CLK) $rose(cur.state == ST_FAILSAFE));
   c_irq: cover property (@(posedge SYS_CLK) $rose(OSC_FAIL_IRQ));
   c_exit_select: cover property (@(posedge SYS_CLK)
      cur.state == ST_FAILSAFE ##1 cur.state == ST_STARTUP);
   c_startup_done: cover property (@(posedge SYS_CLK) $rose(USE_EXTERNAL_CLK));
endmodule // clock_fail_monitor

// [tb/ext_osc_model.sv]
// behavioural external primary oscillator that can die and recover on command
`timescale 1ns/1ns
module ext_osc_model (
   input wire logic sys_clk,
   input wire logic run,
   output logic osc_out
);
   logic [1:0] count = 2'h0;
   initial osc_out = 1'b0;
   // toggle every four cycles while alive, freeze at the last level when dead
   always @(posedge sys_clk) begin
      if (run) begin
         count <= count + 2'h1;
         if (count == 2'h3) begin
            osc_out <= ~osc_out;
         end
      end
   end
endmodule // ext_osc_model

// [tb/test_clock_fail_monitor.sv]
// self-checking bench for the fail-safe clock monitor
`timescale 1ns/1ns
module test_clock_fail_monitor;
   import clock_fail_monitor_pkg::*;
   typedef struct {logic [2:0] mode; logic slow_start;} row_t;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, MONITOR_ENABLE_FUSE = 1'b1, TWO_SPEED_FUSE = 1'b0;
   logic SLEEP_EXEC = 1'b0, WAKE_UP = 1'b0, WR = 1'b0, RD = 1'b0, run = 1'b1, wd;
   logic [2:0] OSC_MODE_CONFIG = MODE_EXTERNAL;
   logic [15:0] ADDR = 16'h0000;
   logic [7:0] WDATA = 8'h00, RDATA, d;
   logic PRIMARY_CLK, OSC_FAIL_IRQ, USE_EXTERNAL_CLK, WATCHDOG_CLEAR, TWO_SPEED_ENABLE;
   logic [2:0] INT_OSC_FREQ;
   int failures = 0, samples_checked = 0, cycles = 0;
   row_t rows[5] = '{'{MODE_LOW_POWER, 1'b1}, '{MODE_CRYSTAL, 1'b1},
      '{MODE_HIGH_SPEED, 1'b1}, '{MODE_EXTERNAL, 1'b0}, '{3'h4, 1'b0}};
   always #4 SYS_CLK = ~SYS_CLK;
   ext_osc_model osc (.sys_clk(SYS_CLK), .run(run), .osc_out(PRIMARY_CLK));
   clock_fail_monitor dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .PRIMARY_CLK(PRIMARY_CLK),
      .OSC_MODE_CONFIG(OSC_MODE_CONFIG), .MONITOR_ENABLE_FUSE(MONITOR_ENABLE_FUSE),
      .TWO_SPEED_FUSE(TWO_SPEED_FUSE), .SLEEP_EXEC(SLEEP_EXEC), .WAKE_UP(WAKE_UP),
      .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .OSC_FAIL_IRQ(OSC_FAIL_IRQ),
      .USE_EXTERNAL_CLK(USE_EXTERNAL_CLK), .INT_OSC_FREQ(INT_OSC_FREQ),
      .WATCHDOG_CLEAR(WATCHDOG_CLEAR), .TWO_SPEED_ENABLE(TWO_SPEED_ENABLE));
   // ends the run with the counts and the verdict
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // register port cycles, read data taken in the cycle after the strobe
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   task rd(input logic [15:0] a, output logic [7:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 v = RDATA;
   endtask
   task do_reset(input logic [2:0] m, input logic fuse);
      @(posedge SYS_CLK);
      RST_N <= 1'b0;
      OSC_MODE_CONFIG <= m;
      MONITOR_ENABLE_FUSE <= fuse;
      run <= 1'b1;
      repeat (5) @(posedge SYS_CLK);
      RST_N <= 1'b1;
   endtask
   // kill the oscillator and wait, bounded, for the failure to be declared
   task make_fail;
      wd = 1'b0;
      run <= 1'b0;
      for (int i = 0; i < 200 && OSC_FAIL_IRQ !== 1'b1; i++) begin
         @(posedge SYS_CLK);
         #1 if (WATCHDOG_CLEAR === 1'b1) wd = 1'b1;
      end
      check(8'(OSC_FAIL_IRQ), 8'h01);
      check(8'(USE_EXTERNAL_CLK), 8'h00);
      check(8'(wd), 8'h01);
      rd(PERIPH_FLAG_TWO_ADDR, d);
      check(8'(d[FAIL_BIT]), 8'h01);
   endtask
   // hang guard
   always @(posedge SYS_CLK) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         $display("mismatch at %0t: timeout", $time);
         close_out;
      end
   end
   initial begin
      foreach (rows[i]) begin
         do_reset(rows[i].mode, 1'b1);
         repeat (100) @(posedge SYS_CLK);
         #1 check(8'(USE_EXTERNAL_CLK), 8'(!rows[i].slow_start));
         check(8'(INT_OSC_FREQ), 8'(FREQ_RESET));
         check(8'(TWO_SPEED_ENABLE), 8'h01);
         if (rows[i].slow_start) begin
            repeat (8060) @(posedge SYS_CLK);
            #1 check(8'(USE_EXTERNAL_CLK), 8'h00);
            repeat (80) @(posedge SYS_CLK);
            #1 check(8'(USE_EXTERNAL_CLK), 8'h01);
         end
         $display("start-up in mode %0d done", rows[i].mode);
      end
      // failure, refused flag clear, exit by select change
      do_reset(MODE_EXTERNAL, 1'b1);
      repeat (20) @(posedge SYS_CLK);
      rd(OSC_CONTROL_ADDR, d);
      check(d, 8'h6E);
      rd(OSC_TUNING_ADDR, d);
      check(d, 8'h00);
      rd(16'h0055, d);
      check(d, 8'h00);
      wr(PERIPH_INT_EN_TWO_ADDR, 8'h80);
      make_fail;
      rd(OSC_CONTROL_ADDR, d);
      check(d, 8'h66);
      wr(PERIPH_FLAG_TWO_ADDR, 8'h00);
      rd(PERIPH_FLAG_TWO_ADDR, d);
      check(8'(d[FAIL_BIT]), 8'h01);
      run <= 1'b1;
      repeat (20) @(posedge SYS_CLK);
      #1 check(8'(USE_EXTERNAL_CLK), 8'h00);
      wr(OSC_CONTROL_ADDR, 8'h61);
      wr(OSC_CONTROL_ADDR, 8'h21);
      #1 check(8'(INT_OSC_FREQ), 8'h02);
      wr(PERIPH_FLAG_TWO_ADDR, 8'h00);
      rd(PERIPH_FLAG_TWO_ADDR, d);
      check(8'(d[FAIL_BIT]), 8'h00);
      check(8'(OSC_FAIL_IRQ), 8'h00);
      $display("failure and select exit done");
      // failure cleared by sleep, monitoring again after wake
      do_reset(MODE_EXTERNAL, 1'b1);
      wr(PERIPH_INT_EN_TWO_ADDR, 8'h80);
      make_fail;
      @(posedge SYS_CLK);
      SLEEP_EXEC <= 1'b1;
      @(posedge SYS_CLK);
      SLEEP_EXEC <= 1'b0;
      wr(PERIPH_FLAG_TWO_ADDR, 8'h00);
      rd(PERIPH_FLAG_TWO_ADDR, d);
      check(8'(d[FAIL_BIT]), 8'h00);
      run <= 1'b1;
      // let the oscillator settle so no stale failure lands after wake
      repeat (100) @(posedge SYS_CLK);
      WAKE_UP <= 1'b1;
      @(posedge SYS_CLK);
      WAKE_UP <= 1'b0;
      repeat (100) @(posedge SYS_CLK);
      #1 check(8'(USE_EXTERNAL_CLK), 8'h01);
      $display("sleep exit done");
      // monitor off: a dead clock goes unnoticed
      do_reset(MODE_EXTERNAL, 1'b0);
      wr(PERIPH_INT_EN_TWO_ADDR, 8'h80);
      run <= 1'b0;
      repeat (300) @(posedge SYS_CLK);
      #1 check(8'(OSC_FAIL_IRQ), 8'h00);
      check(8'(USE_EXTERNAL_CLK), 8'h01);
      check(8'(TWO_SPEED_ENABLE), 8'h00);
      $display("monitor disabled done");
      close_out;
   end
endmodule // test_clock_fail_monitor
